// [core/jdp_pkg.sv]
// constants and types shared by the debug test port
package jdp_pkg;

	// ****************************************
	// instruction register
	// ****************************************
	localparam int JDP_IR_W = 4; // instruction width
	localparam logic [3:0] JDP_IR_CAPTURE = 4'h1; // loaded in capture-ir
	localparam logic [3:0] JDP_INS_IDCODE = 4'h1; // identity word
	localparam logic [3:0] JDP_INS_DBGSTAT = 4'h2; // read core status
	localparam logic [3:0] JDP_INS_DBGCMD = 4'h3; // write debug command
	localparam logic [3:0] JDP_INS_BYPASS = 4'hf; // one-bit path

	// ****************************************
	// data registers and timing
	// ****************************************
	localparam int JDP_ID_W = 32; // identity register width
	// arbitrary identity value; lsb must stay 1
	localparam logic [31:0] JDP_ID_DEFAULT = 32'h00000001;
	localparam int JDP_DBG_W = 16; // default debug word width
	localparam logic [2:0] JDP_PULSE_CYCLES = 3'h4; // event low width

	// ****************************************
	// tap controller states
	// ****************************************
	typedef enum logic [3:0] {
		JDP_TLR, JDP_RTI,
		JDP_SEL_DR, JDP_CAP_DR, JDP_SHF_DR, JDP_EX1_DR,
		JDP_PAU_DR, JDP_EX2_DR, JDP_UPD_DR,
		JDP_SEL_IR, JDP_CAP_IR, JDP_SHF_IR, JDP_EX1_IR,
		JDP_PAU_IR, JDP_EX2_IR, JDP_UPD_IR
	} jdp_tap_state_t;

endpackage

// [core/jdp_tap_fsm.sv]
// sixteen-state tap controller stepped by the mode-select input
module jdp_tap_fsm
	import jdp_pkg::*;
(
	// test clock and reset
	input wire logic tck,
	input wire logic trstN,
	// mode select
	input wire logic tms,
	// current state
	output jdp_tap_state_t tapState
);

	jdp_tap_state_t next_tapState; // state after this edge

	// ****************************************
	// next state
	// ****************************************
	// standard transition table, tms chooses the branch
	always_comb
	begin
		next_tapState = tapState;
		unique case (tapState)
			JDP_TLR: next_tapState = tms ? JDP_TLR : JDP_RTI;
			JDP_RTI: next_tapState = tms ? JDP_SEL_DR : JDP_RTI;
			JDP_SEL_DR: next_tapState = tms ? JDP_SEL_IR : JDP_CAP_DR;
			JDP_CAP_DR: next_tapState = tms ? JDP_EX1_DR : JDP_SHF_DR;
			JDP_SHF_DR: next_tapState = tms ? JDP_EX1_DR : JDP_SHF_DR;
			JDP_EX1_DR: next_tapState = tms ? JDP_UPD_DR : JDP_PAU_DR;
			JDP_PAU_DR: next_tapState = tms ? JDP_EX2_DR : JDP_PAU_DR;
			JDP_EX2_DR: next_tapState = tms ? JDP_UPD_DR : JDP_SHF_DR;
			JDP_UPD_DR: next_tapState = tms ? JDP_SEL_DR : JDP_RTI;
			JDP_SEL_IR: next_tapState = tms ? JDP_TLR : JDP_CAP_IR;
			JDP_CAP_IR: next_tapState = tms ? JDP_EX1_IR : JDP_SHF_IR;
			JDP_SHF_IR: next_tapState = tms ? JDP_EX1_IR : JDP_SHF_IR;
			JDP_EX1_IR: next_tapState = tms ? JDP_UPD_IR : JDP_PAU_IR;
			JDP_PAU_IR: next_tapState = tms ? JDP_EX2_IR : JDP_PAU_IR;
			JDP_EX2_IR: next_tapState = tms ? JDP_UPD_IR : JDP_SHF_IR;
			JDP_UPD_IR: next_tapState = tms ? JDP_SEL_DR : JDP_RTI;
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	// only the test reset clears it; device reset never reaches here
	always_ff @(posedge tck or negedge trstN)
	begin
		if (!trstN)
			tapState <= JDP_TLR;
		else
			tapState <= next_tapState;
	end

	// ****************************************
	// checks
	// ****************************************
	property p_five_high_reset;
		@(posedge tck) disable iff (!trstN)
		tms [*5] |=> tapState == JDP_TLR;
	endproperty
	a_five_high_reset: assert property (p_five_high_reset)
		else $error("five tms highs did not reach test-logic-reset");

	property p_idle_step;
		@(posedge tck) disable iff (!trstN)
		(tapState == JDP_RTI && tms) |=> tapState == JDP_SEL_DR;
	endproperty
	a_idle_step: assert property (p_idle_step)
		else $error("tms high in idle did not select dr scan");

endmodule

// [core/jdp_debug_port.sv]
// test access port with debug command, status and event pulse
//
// Summary of operation
// - probe supplies test clock; pin pulled low.
// - mode select sampled rising edge, steps tap.
// - data input sampled on rising test-clock edge.
// - data output driven only in shift states.
// - data output changes on falling test-clock edge.
// - test reset low resets tap asynchronously.
// - hardware reset alone leaves tap, debug command untouched.
// - low pulse on each recognised debug event.
module jdp_debug_port
	import jdp_pkg::*;
#(
	parameter int DW = JDP_DBG_W, // debug word width
	parameter logic [31:0] ID_VALUE = JDP_ID_DEFAULT // arbitrary id
)
(
	// system clock and device reset
	input wire logic mclk,
	input wire logic srst,
	// probe link
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trstN,
	output logic tdo,
	output logic tdoOeN,
	// core side
	input wire logic dbgEventIn,
	input wire logic [DW-1:0] debugStatus,
	output logic [DW-1:0] debugCmd,
	output logic debugCmdStrobe,
	// event pin
	output logic debugEventPulseN
);

	// ****************************************
	// test clock domain
	// ****************************************
	jdp_tap_state_t tapState; // controller state
	logic [JDP_IR_W-1:0] irShift; // instruction shift path
	logic [JDP_IR_W-1:0] irReg; // active instruction
	logic [JDP_ID_W-1:0] idShift; // identity shift path
	logic [DW-1:0] dbgShift; // debug shift path
	logic [DW-1:0] cmdTck; // last command written
	logic [DW-1:0] statusTck; // status copy for capture
	logic bypassBit; // bypass path
	logic updToggle; // flips on each command update
	logic reqS1; // status request sync, first
	logic reqS2; // status request sync, second
	logic reqSeen; // status request taken, acts as ack
	logic tdoSrc; // bit to present at next fall
	logic shiftNow; // in a shift state
	logic reqT; // status request toggle, from the system side
	logic [DW-1:0] statusHold; // status word held for crossing

	// tap controller, clocked only by the probe clock
	jdp_tap_fsm u_fsm
	(
		.tck(tck),
		.trstN(trstN),
		.tms(tms),
		.tapState(tapState)
	);

	assign shiftNow = (tapState == JDP_SHF_DR) ||
		(tapState == JDP_SHF_IR);

	// instruction path: capture, shift, update
	always_ff @(posedge tck or negedge trstN)
	begin
		if (!trstN)
		begin
			irShift <= JDP_IR_CAPTURE;
			irReg <= JDP_INS_IDCODE;
		end
		else
		begin
			unique case (tapState)
				JDP_TLR: irReg <= JDP_INS_IDCODE;
				JDP_CAP_IR: irShift <= JDP_IR_CAPTURE;
				// new bit enters at the far end
				JDP_SHF_IR: irShift <= {tdi, irShift[JDP_IR_W-1:1]};
				JDP_UPD_IR: irReg <= irShift;
				default:
				begin
					irShift <= irShift;
				end
			endcase
		end
	end

	// data paths selected by the active instruction
	always_ff @(posedge tck or negedge trstN)
	begin
		if (!trstN)
		begin
			idShift <= '0;
			dbgShift <= '0;
			bypassBit <= 1'b0;
		end
		else if (tapState == JDP_CAP_DR)
		begin
			unique case (irReg)
				JDP_INS_IDCODE: idShift <= ID_VALUE;
				JDP_INS_DBGSTAT: dbgShift <= statusTck;
				JDP_INS_DBGCMD: dbgShift <= cmdTck; // read back
				default: bypassBit <= 1'b0;
			endcase
		end
		else if (tapState == JDP_SHF_DR)
		begin
			// tdi sampled on this rising edge
			unique case (irReg)
				JDP_INS_IDCODE: idShift <= {tdi, idShift[JDP_ID_W-1:1]};
				JDP_INS_DBGSTAT, JDP_INS_DBGCMD:
					dbgShift <= {tdi, dbgShift[DW-1:1]};
				default: bypassBit <= tdi;
			endcase
		end
	end

	// command update; the toggle tells the system side
	always_ff @(posedge tck or negedge trstN)
	begin
		if (!trstN)
		begin
			cmdTck <= '0;
			updToggle <= 1'b0;
		end
		else if (tapState == JDP_UPD_DR && irReg == JDP_INS_DBGCMD)
		begin
			cmdTck <= dbgShift;
			updToggle <= ~updToggle;
		end
	end

	// status handshake, receiving end; holds while clock stops
	always_ff @(posedge tck or negedge trstN)
	begin
		if (!trstN)
		begin
			reqS1 <= 1'b0;
			reqS2 <= 1'b0;
			reqSeen <= 1'b0;
			statusTck <= '0;
		end
		else
		begin
			reqS1 <= reqT;
			reqS2 <= reqS1;
			// sender holds statusHold until this ack returns
			if (reqS2 != reqSeen)
			begin
				statusTck <= statusHold;
				reqSeen <= reqS2;
			end
		end
	end

	// bit that the probe will see
	always_comb
	begin
		if (tapState == JDP_SHF_IR)
			tdoSrc = irShift[0];
		else
		begin
			unique case (irReg)
				JDP_INS_IDCODE: tdoSrc = idShift[0];
				JDP_INS_DBGSTAT, JDP_INS_DBGCMD: tdoSrc = dbgShift[0];
				default: tdoSrc = bypassBit;
			endcase
		end
	end

	// output stage on the falling edge, half a cycle of setup
	always_ff @(negedge tck or negedge trstN)
	begin
		if (!trstN)
		begin
			tdo <= 1'b0;
			tdoOeN <= 1'b1; // released during reset
		end
		else
		begin
			tdo <= tdoSrc;
			tdoOeN <= !shiftNow;
		end
	end

	// ****************************************
	// system clock domain
	// ****************************************
	logic trstS1; // test reset sync, first
	logic trstS2; // test reset sync, second
	logic dbgRst; // debug-side reset, from test reset only
	logic updS1; // update toggle sync, first
	logic updS2; // update toggle sync, second
	logic updSeen; // last toggle acted on
	logic cmdLoad; // a new command has arrived
	logic ackS1; // ack sync, first
	logic ackS2; // ack sync, second
	logic eventFire; // a recognised debug event
	logic [2:0] pulseCnt; // remaining low cycles

	// test reset into this domain; relies on the system pairing
	// it with the hardware reset for a full clear
	always_ff @(posedge mclk)
	begin
		trstS1 <= trstN;
		trstS2 <= trstS1;
	end

	assign dbgRst = !trstS2;

	// command toggle crossing; srst is kept out on purpose
	always_ff @(posedge mclk)
	begin
		if (dbgRst)
		begin
			updS1 <= 1'b0;
			updS2 <= 1'b0;
			updSeen <= 1'b0;
		end
		else
		begin
			updS1 <= updToggle;
			updS2 <= updS1;
			updSeen <= updS2;
		end
	end

	assign cmdLoad = updS2 != updSeen;

	// command word; cmdTck stays put long after the toggle flips
	always_ff @(posedge mclk)
	begin
		if (dbgRst)
			debugCmd <= '0;
		else if (cmdLoad)
			debugCmd <= cmdTck;
	end

	// strobe marks the new command for one cycle
	always_ff @(posedge mclk)
	begin
		if (srst || dbgRst)
			debugCmdStrobe <= 1'b0;
		else
			debugCmdStrobe <= cmdLoad;
	end

	// status request side; a stopped probe clock just stalls it
	always_ff @(posedge mclk)
	begin
		if (dbgRst)
		begin
			reqT <= 1'b0;
			statusHold <= '0;
			ackS1 <= 1'b0;
			ackS2 <= 1'b0;
		end
		else
		begin
			ackS1 <= reqSeen;
			ackS2 <= ackS1;
			// only reload after the previous word was taken
			if (ackS2 == reqT)
			begin
				statusHold <= debugStatus;
				reqT <= ~reqT;
			end
		end
	end

	// events: core request or a written command
	assign eventFire = dbgEventIn || cmdLoad;

	// low pulse generator; a new event restarts the width
	always_ff @(posedge mclk)
	begin
		if (srst || dbgRst)
		begin
			pulseCnt <= '0;
			debugEventPulseN <= 1'b1;
		end
		else
		begin
			if (eventFire)
				pulseCnt <= JDP_PULSE_CYCLES;
			else if (pulseCnt != '0)
				pulseCnt <= pulseCnt - 3'h1;
			debugEventPulseN <= !(eventFire || pulseCnt > 3'h1);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_oe_shift;
		@(posedge tck) disable iff (!trstN)
		!tdoOeN == shiftNow;
	endproperty
	a_oe_shift: assert property (p_oe_shift)
		else $error("data output enable outside shift states");

	property p_tdo_value;
		@(posedge tck) disable iff (!trstN)
		!tdoOeN |-> tdo == tdoSrc;
	endproperty
	a_tdo_value: assert property (p_tdo_value)
		else $error("data output not the current shift bit");

	property p_tdi_in;
		@(posedge tck) disable iff (!trstN)
		(tapState == JDP_SHF_DR && irReg == JDP_INS_DBGCMD)
			|=> dbgShift[DW-1] == $past(tdi);
	endproperty
	a_tdi_in: assert property (p_tdi_in)
		else $error("data input bit not shifted in");

	property p_trst_clears;
		@(posedge tck) !trstN |-> tapState == JDP_TLR && tdoOeN;
	endproperty
	a_trst_clears: assert property (p_trst_clears)
		else $error("test reset did not clear controller");

	property p_srst_keeps;
		@(posedge mclk) disable iff (dbgRst)
		(srst && !cmdLoad) |=> $stable(debugCmd);
	endproperty
	a_srst_keeps: assert property (p_srst_keeps)
		else $error("device reset disturbed debug command");

	property p_pulse_width;
		@(posedge mclk) disable iff (srst || dbgRst)
		eventFire |=> !debugEventPulseN [*4];
	endproperty
	a_pulse_width: assert property (p_pulse_width)
		else $error("event pulse shorter than four cycles");

	property p_pulse_end;
		@(posedge mclk) disable iff (srst || dbgRst)
		(pulseCnt == 3'h1 && !eventFire) |=> debugEventPulseN;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("event pulse did not end");

	property p_cmd_strobe;
		@(posedge mclk) disable iff (srst || dbgRst)
		cmdLoad |=> debugCmdStrobe && debugCmd == $past(cmdTck);
	endproperty
	a_cmd_strobe: assert property (p_cmd_strobe)
		else $error("command not delivered with strobe");

	c_event: cover property (@(posedge mclk) disable iff (srst)
		$fell(debugEventPulseN));
	c_cmd: cover property (@(posedge mclk) disable iff (srst)
		debugCmdStrobe);
	c_shift_dr: cover property (@(posedge tck) disable iff (!trstN)
		tapState == JDP_SHF_DR && !tdoOeN);

endmodule

// [bench/jdp_probe_model.sv]
// behavioural debug probe driving the test access port pins
module jdp_probe_model
(
	// probe drive
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trstN,
	// device answer
	input wire logic tdo,
	input wire logic tdoOeN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lastTdo = 1'b0; // last value the device drove
	logic tdoSeen; // wire level at the probe
	// released wire must not look like valid data
	always @(negedge tck)
		if (!tdoOeN)
			lastTdo <= tdo;
	assign tdoSeen = tdoOeN ? ~lastTdo : tdo;
	initial
	begin
		tck = 1'b0; // stands low outside frames
		tms = 1'b1;
		tdi = 1'b1;
		trstN = 1'b1;
		// a real falling edge, so the async clear is never missed
		#1;
		trstN = 1'b0; // low together with system reset
	end
	// test reset level
	task automatic rst(input logic v);
		trstN = v;
	endtask
	// one 32 ns period; sample just before the rise
	task automatic clk(input logic m, input logic d, output logic q,
		output logic oe);
		tms = m;
		tdi = d;
		#8;
		q = tdoSeen;
		oe = tdoOeN;
		tck = 1'b1;
		#16;
		tck = 1'b0;
		#8;
	endtask
	// five highs reach test-logic-reset, then idle
	task automatic idle();
		logic q;
		logic oe;
		repeat (5) clk(1'b1, 1'b0, q, oe);
		clk(1'b0, 1'b0, q, oe);
	endtask
	// from idle: scan n bits lsb first, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout, output logic oeHi);
		logic q;
		logic oe;
		dout = '0;
		oeHi = 1'b0;
		clk(1'b1, 1'b0, q, oe);
		if (ir)
			clk(1'b1, 1'b0, q, oe);
		clk(1'b0, 1'b0, q, oe);
		clk(1'b0, 1'b0, q, oe);
		for (int i = 0; i < n; i++)
		begin
			clk(i == n - 1, din[i], dout[i], oe);
			oeHi |= oe;
		end
		clk(1'b1, 1'b0, q, oe);
		clk(1'b0, 1'b0, q, oe);
	endtask
endmodule

// [bench/jdp_debug_port_bench.sv]
// self-checking bench for the debug test port
module jdp_debug_port_bench
	import jdp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID_TEST = 32'h13579bdf; // arbitrary, lsb 1
	logic mclk, srst, tck, tms, tdi, trstN, tdo, tdoOeN;
	logic dbgEventIn, debugCmdStrobe, debugEventPulseN;
	logic [JDP_DBG_W-1:0] debugStatus, debugCmd;
	int nMismatch = 0;
	int nChecks = 0;
	int nStrobe = 0; // command strobes seen
	logic [3:0] codes [4] = '{JDP_INS_IDCODE, JDP_INS_DBGSTAT,
		JDP_INS_BYPASS, 4'h7};

	jdp_debug_port #(.DW(JDP_DBG_W), .ID_VALUE(ID_TEST)) jdp_debug_port_inst
	(
		.mclk(mclk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
		.trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN), .dbgEventIn(dbgEventIn),
		.debugStatus(debugStatus), .debugCmd(debugCmd),
		.debugCmdStrobe(debugCmdStrobe), .debugEventPulseN(debugEventPulseN)
	);
	jdp_probe_model jdp_probe_model_inst
	(
		.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
		.tdo(tdo), .tdoOeN(tdoOeN)
	);

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// expected data scan result per instruction
	function automatic logic [31:0] drExpect(logic [3:0] c, logic [31:0] v);
		if (c == JDP_INS_IDCODE)
			return ID_TEST;
		if (c == JDP_INS_DBGSTAT)
			return {v[15:0], v[31:16]};
		return {v[30:0], 1'b0};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic endSim();
		$display("checks %0d mismatches %0d", nChecks, nMismatch);
		if (nMismatch == 0 && nChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// count strobes where they stand, away from the launch edge
	always @(negedge mclk)
		if (debugCmdStrobe === 1'b1)
			nStrobe++;

	// low width of next event pulse, bounded waits
	task automatic eventWidth(output int w);
		int k;
		w = 0;
		k = 0;
		while (debugEventPulseN !== 1'b0 && k < 20)
		begin
			@(negedge mclk);
			k++;
		end
		while (debugEventPulseN === 1'b0 && w < 20)
		begin
			@(negedge mclk);
			w++;
		end
	endtask

	initial
	begin
		#500000;
		nMismatch++;
		endSim();
	end

	initial
	begin
		logic [31:0] got;
		logic [31:0] val;
		logic oeHi;
		logic q;
		int w;
		logic [15:0] prev;
		void'($urandom(3438));
		srst = 1'b1;
		dbgEventIn = 1'b0;
		debugStatus = '0;
		repeat (11) @(negedge mclk);
		// one test clock rise while test reset is still low
		jdp_probe_model_inst.clk(1'b1, 1'b1, q, oeHi);
		@(negedge mclk);
		check({31'h0, tdoOeN}, 32'h1);
		check({31'h0, debugEventPulseN}, 32'h1);
		srst = 1'b0;
		jdp_probe_model_inst.rst(1'b1);
		repeat (4) @(negedge mclk);
		jdp_probe_model_inst.idle();
		jdp_probe_model_inst.scan(1'b0, 32, $urandom, got, oeHi);
		check(got, ID_TEST);
		check({31'h0, tdoOeN}, 32'h1);
		foreach (codes[i])
		begin
			val = $urandom;
			@(negedge mclk);
			debugStatus = val[31:16];
			repeat (10) @(negedge mclk);
			// test clock must run for the status word to cross
			jdp_probe_model_inst.idle();
			jdp_probe_model_inst.scan(1'b1, 4, {28'h0, codes[i]}, got, oeHi);
			check(got, {28'h0, JDP_IR_CAPTURE});
			jdp_probe_model_inst.scan(1'b0, 32, val, got, oeHi);
			check(got, drExpect(codes[i], val));
			check({31'h0, oeHi}, 32'h0);
		end
		// command write, then device reset alone keeps tap and command
		jdp_probe_model_inst.scan(1'b1, 4, {28'h0, JDP_INS_DBGCMD}, got, oeHi);
		prev = '0;
		for (int r = 0; r < 2; r++)
		begin
			val = $urandom;
			jdp_probe_model_inst.scan(1'b0, 16, val, got, oeHi);
			check(got, {16'h0, prev});
			eventWidth(w);
			check(debugCmd, val[15:0]);
			check(w, 4);
			check(nStrobe, r + 1);
			prev = val[15:0];
			@(negedge mclk);
			srst = 1'b1;
			repeat (2) @(negedge mclk);
			srst = 1'b0;
			check(debugCmd, val[15:0]);
		end
		// single and retriggered core events
		for (int g = 0; g <= 2; g += 2)
		begin
			fork
				eventWidth(w);
				begin
					@(negedge mclk);
					dbgEventIn = 1'b1;
					@(negedge mclk);
					dbgEventIn = 1'b0;
					repeat (g - 1) @(negedge mclk);
					dbgEventIn = (g > 0);
					@(negedge mclk);
					dbgEventIn = 1'b0;
				end
			join
			check(w, 4 + g);
		end
		// five highs from a loaded bypass restore identity
		jdp_probe_model_inst.scan(1'b1, 4, {28'h0, JDP_INS_BYPASS}, got, oeHi);
		jdp_probe_model_inst.idle();
		jdp_probe_model_inst.scan(1'b0, 32, 32'h0, got, oeHi);
		check(got, ID_TEST);
		// test reset in mid-shift releases the pin immediately
		jdp_probe_model_inst.clk(1'b1, 1'b0, q, oeHi);
		repeat (3) jdp_probe_model_inst.clk(1'b0, 1'b0, q, oeHi);
		check({31'h0, tdoOeN}, 32'h0);
		jdp_probe_model_inst.rst(1'b0);
		#5;
		check({31'h0, tdoOeN}, 32'h1);
		repeat (5) @(negedge mclk);
		check(debugCmd, '0);
		check(nStrobe, 2);
		endSim();
	end
endmodule
